// >>> logic/dcrc_bus_if.sv
// Peripheral bus wires between the I/O processor and one device
`timescale 1ns/10ps
`default_nettype none
interface dcrc_bus_if;
   // Priority chain level into the device and out to the next one
   logic chan_priority_enable;
   logic chan_priority_enable_out;
   // Open-drain request pins: enables from the device, wire levels
   logic chan_request_oe_n;
   logic single_cycle_request_oe_n;
   logic chan_request_n;
   logic single_cycle_request_n;
   logic chan_grant;
   logic [dcrc_pkg::DS_W-1:0] dev_select;
   logic io_transfer_instruction;
   // Active-low address bus, device to processor
   logic io_addr_oe_n;
   logic [dcrc_pkg::ADDR_W-1:0] io_addr_out_n;
   logic [dcrc_pkg::ADDR_W-1:0] io_addr_n;

   // Released lines float high through the bus terminators
   assign chan_request_n = chan_request_oe_n;
   assign single_cycle_request_n = single_cycle_request_oe_n;
   assign io_addr_n = io_addr_oe_n ? '1 : io_addr_out_n;

   modport device (
      input chan_priority_enable,
      output chan_priority_enable_out,
      output chan_request_oe_n,
      output single_cycle_request_oe_n,
      input chan_grant,
      input dev_select,
      input io_transfer_instruction,
      output io_addr_oe_n,
      output io_addr_out_n
   );

   modport processor (
      output chan_priority_enable,
      input chan_request_n,
      input single_cycle_request_n,
      output chan_grant,
      output dev_select,
      output io_transfer_instruction,
      input io_addr_n
   );
endinterface : dcrc_bus_if
`default_nettype wire

// >>> logic/dcrc_device_end.sv
// Device end of the data channel request chain
`timescale 1ns/10ps
`default_nettype none
module dcrc_device_end #(
   parameter logic [5:0] DEV_CODE = 6'h01,
   parameter int ADDR_W = 15
) (
   input wire logic i_clk,                      // System clock
   input wire logic i_reset_n,                  // Async reset, low
   dcrc_bus_if.device bus,                      // Peripheral bus
   input wire logic i_xfer_start,               // Start pulse
   input wire dcrc_pkg::dcrc_xfer_t i_xfer_type, // Kind of transfer
   input wire logic [ADDR_W-1:0] i_wc_addr,     // Word count address
   input wire logic [ADDR_W-1:0] i_mem_addr,    // Memory address
   output logic o_busy,                         // Transfer in progress
   output logic o_requesting,                   // Request posted
   output logic o_granted,                      // Grant held
   output logic o_done,                         // Grant ended pulse
   output logic o_selected                      // Own code addressed
);

   // Elaboration checks
   generate
      if (ADDR_W != dcrc_pkg::ADDR_W) begin : g_bad_addr_w
         $error("ADDR_W must match the bus address width");
      end
      if ($bits(DEV_CODE) != dcrc_pkg::DS_W) begin : g_bad_code_w
         $error("DEV_CODE must be as wide as the select lines");
      end
   endgenerate

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PEND = 2'b01,
      ST_REQ = 2'b10,
      ST_GRANT = 2'b11
   } dcrc_dev_state_t;

   // States in which this device owns the chain below it
   function automatic logic holds_chain(input dcrc_dev_state_t st);
      holds_chain = (st == ST_REQ) || (st == ST_GRANT);
   endfunction : holds_chain

   // Multicycle work names its word count location, single-cycle
   // work names the memory word itself
   function automatic logic [ADDR_W-1:0] start_addr(
      input dcrc_pkg::dcrc_xfer_t xfer,
      input logic [ADDR_W-1:0] wc_addr,
      input logic [ADDR_W-1:0] mem_addr
   );
      if (xfer == dcrc_pkg::XFER_MULTI) begin
         start_addr = wc_addr;
      end else begin
         start_addr = mem_addr;
      end
   endfunction : start_addr

   dcrc_dev_state_t state_q;
   dcrc_dev_state_t state_d;
   dcrc_pkg::dcrc_xfer_t type_q;
   dcrc_pkg::dcrc_xfer_t type_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic [1:0] req_pins_q;
   logic [1:0] req_pins_d;
   logic done_q;
   logic done_d;
   logic sel_q;
   logic sel_d;
   logic chain_blocked;
   logic busy_q;
   logic busy_d;
   logic posted_q;
   logic posted_d;
   logic granted_q;
   logic granted_d;

   // Transfer sequencing
   always_comb begin
      state_d = state_q;
      type_d = type_q;
      addr_d = addr_q;
      req_pins_d = req_pins_q;
      done_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            // A start with no transfer type asks for nothing. Starts
            // while busy are dropped, not queued: wait for o_done.
            if (i_xfer_start
                && i_xfer_type != dcrc_pkg::XFER_NONE) begin
               type_d = i_xfer_type;
               addr_d = start_addr(i_xfer_type, i_wc_addr, i_mem_addr);
               state_d = ST_PEND;
            end
         end
         ST_PEND: begin
            // Wait here while a device upstream holds the chain
            if (bus.chan_priority_enable) begin
               req_pins_d = dcrc_pkg::req_pins(type_q);
               state_d = ST_REQ;
            end
         end
         ST_REQ: begin
            // Once posted the request stays until granted, even if
            // a device above takes the chain meanwhile
            if (bus.chan_grant) begin
               req_pins_d = {2{dcrc_pkg::PIN_RELEASED}};
               state_d = ST_GRANT;
            end
         end
         ST_GRANT: begin
            if (!bus.chan_grant) begin
               done_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         type_q <= dcrc_pkg::XFER_NONE;
         addr_q <= '0;
         req_pins_q <= {2{dcrc_pkg::PIN_RELEASED}};
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         type_q <= type_d;
         addr_q <= addr_d;
         req_pins_q <= req_pins_d;
         done_q <= done_d;
      end
   end

   // Device select decode
   always_comb begin
      sel_d = bus.io_transfer_instruction
              && (bus.dev_select == DEV_CODE);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
      end
   end

   // Chain pass-through. Cut from the next state so that the level
   // falls one cycle before the request is posted; a device below
   // therefore can never post alongside this one.
   always_comb begin
      chain_blocked = holds_chain(state_d);
   end

   assign bus.chan_priority_enable_out =
      bus.chan_priority_enable && !chain_blocked;

   assign bus.chan_request_oe_n = req_pins_q[1];
   assign bus.single_cycle_request_oe_n = req_pins_q[0];

   // The address follows the grant level without a clock delay, so
   // the processor may sample it on the grant's next edge
   assign bus.io_addr_oe_n =
      !(bus.chan_grant && holds_chain(state_q));
   assign bus.io_addr_out_n = ~addr_q;

   // Status levels come from flops fed by the next state, so they
   // line up with state_q without a decode glitch on the outputs
   always_comb begin
      busy_d = (state_d != ST_IDLE);
      posted_d = (state_d == ST_REQ);
      granted_d = (state_d == ST_GRANT);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_q <= 1'b0;
         posted_q <= 1'b0;
         granted_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         posted_q <= posted_d;
         granted_q <= granted_d;
      end
   end

   assign o_busy = busy_q;
   assign o_requesting = posted_q;
   assign o_granted = granted_q;
   assign o_done = done_q;
   assign o_selected = sel_q;

endmodule : dcrc_device_end
`default_nettype wire

// >>> logic/dcrc_pkg.sv
// Shared constants and helpers for the data channel request chain
package dcrc_pkg;

   // Bus widths
   localparam int ADDR_W = 15;
   localparam int DS_W = 6;

   // Processor grant timing, in i_clk cycles, and the width of its counter
   localparam int GRANT_WAIT = 2;
   localparam int GRANT_HOLD = 3;
   localparam int CNT_W = 4;

   // Reset levels of the bus pins, all released or idle
   localparam logic PIN_RELEASED = 1'b1;
   localparam logic ENABLE_RESET = 1'b0;

   // Transfer type, coded as {chan request, single-cycle request}
   // with both bits active high
   typedef enum logic [1:0] {
      XFER_NONE = 2'b00,
      XFER_OUT = 2'b01,
      XFER_MULTI = 2'b10,
      XFER_IN = 2'b11
   } dcrc_xfer_t;

   // Active-low request pin levels {chan, single} for a transfer type
   function automatic logic [1:0] req_pins(input dcrc_xfer_t xfer);
      req_pins = ~xfer;
   endfunction : req_pins

   // Transfer type seen on the two active-low request pins
   function automatic dcrc_xfer_t req_decode(input logic chan_n,
                                             input logic single_n);
      req_decode = dcrc_xfer_t'({~chan_n, ~single_n});
   endfunction : req_decode

endpackage : dcrc_pkg

// >>> logic/dcrc_proc_end.sv
// I/O processor end of the data channel request chain
`timescale 1ns/10ps
`default_nettype none
module dcrc_proc_end #(
   parameter int ADDR_W = 15,
   parameter int GRANT_WAIT = dcrc_pkg::GRANT_WAIT,
   parameter int GRANT_HOLD = dcrc_pkg::GRANT_HOLD
) (
   input wire logic i_clk,                       // System clock
   input wire logic i_reset_n,                   // Async reset, low
   dcrc_bus_if.processor bus,                    // Peripheral bus
   input wire logic i_chain_enable,              // Allow requests
   input wire logic i_iot_strobe,                // I/O instruction
   input wire logic [5:0] i_iot_dev_code,        // Device code
   output logic o_xfer_valid,                    // Address taken pulse
   output dcrc_pkg::dcrc_xfer_t o_xfer_type,     // Granted kind
   output logic [ADDR_W-1:0] o_xfer_addr,        // Address taken
   output logic o_busy                           // Grant cycle running
);

   generate
      if (ADDR_W != dcrc_pkg::ADDR_W) begin : g_bad_addr_w
         $error("ADDR_W must match the bus address width");
      end
      if (GRANT_WAIT < 1 || GRANT_WAIT > 15) begin : g_bad_wait
         $error("GRANT_WAIT must lie in 1..15");
      end
      if (GRANT_HOLD < 1 || GRANT_HOLD > 15) begin : g_bad_hold
         $error("GRANT_HOLD must lie in 1..15");
      end
   endgenerate

   localparam logic [3:0] WAIT_CNT = 4'(GRANT_WAIT - 1);
   localparam logic [3:0] HOLD_CNT = 4'(GRANT_HOLD - 1);

   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_WAIT = 2'b01,
      PS_HOLD = 2'b10
   } dcrc_proc_state_t;

   dcrc_proc_state_t state_q;
   dcrc_proc_state_t state_d;
   logic [dcrc_pkg::CNT_W-1:0] cnt_q;
   logic [dcrc_pkg::CNT_W-1:0] cnt_d;
   logic grant_q;
   logic grant_d;
   logic valid_q;
   logic valid_d;
   dcrc_pkg::dcrc_xfer_t type_q;
   dcrc_pkg::dcrc_xfer_t type_d;
   dcrc_pkg::dcrc_xfer_t seen;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic en_q;
   logic iot_q;
   logic [5:0] ds_q;

   always_comb begin
      seen = dcrc_pkg::req_decode(bus.chan_request_n,
                                  bus.single_cycle_request_n);
      state_d = state_q;
      cnt_d = cnt_q;
      grant_d = grant_q;
      valid_d = 1'b0;
      type_d = type_q;
      addr_d = addr_q;
      unique case (state_q)
         PS_IDLE: begin
            // Both request pins high means nothing to serve
            if (seen != dcrc_pkg::XFER_NONE) begin
               type_d = seen;
               grant_d = 1'b1;
               cnt_d = WAIT_CNT;
               state_d = PS_WAIT;
            end
         end
         PS_WAIT: begin
            if (cnt_q == '0) begin
               addr_d = ~bus.io_addr_n;
               valid_d = 1'b1;
               cnt_d = HOLD_CNT;
               state_d = PS_HOLD;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         PS_HOLD: begin
            if (cnt_q == '0) begin
               grant_d = 1'b0;
               state_d = PS_IDLE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: begin
            grant_d = 1'b0;
            state_d = PS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= PS_IDLE;
         cnt_q <= '0;
         grant_q <= 1'b0;
         valid_q <= 1'b0;
         type_q <= dcrc_pkg::XFER_NONE;
         addr_q <= '0;
         en_q <= dcrc_pkg::ENABLE_RESET;
         iot_q <= 1'b0;
         ds_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         grant_q <= grant_d;
         valid_q <= valid_d;
         type_q <= type_d;
         addr_q <= addr_d;
         en_q <= i_chain_enable;
         iot_q <= i_iot_strobe;
         ds_q <= i_iot_dev_code;
      end
   end

   // Head of the chain: a steady registered level
   assign bus.chan_priority_enable = en_q;
   assign bus.chan_grant = grant_q;
   assign bus.dev_select = ds_q;
   assign bus.io_transfer_instruction = iot_q;
   assign o_xfer_valid = valid_q;
   assign o_xfer_type = type_q;
   assign o_xfer_addr = addr_q;
   assign o_busy = (state_q != PS_IDLE);

endmodule : dcrc_proc_end
`default_nettype wire

// >>> sim/dcrc_assertions.sv
// Interface checker for the data channel request chain
`timescale 1ns/10ps
`default_nettype none
module dcrc_assertions (
   input wire logic i_clk, // System clock
   input wire logic i_reset_n, // Async reset, low
   input wire logic chan_priority_enable, // Chain in
   input wire logic chan_priority_enable_out, // Chain out
   input wire logic chan_request_n, // Request wire
   input wire logic single_cycle_request_n, // Single wire
   input wire logic chan_grant, // Grant
   input wire logic io_addr_oe_n, // Address enable
   input wire logic [dcrc_pkg::ADDR_W-1:0] io_addr_n // Address wire
);
   logic req_any;
   assign req_any = ~chan_request_n | ~single_cycle_request_n;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_chain_cut:
      assert property (!chan_priority_enable |-> !chan_priority_enable_out)
      else $error("enable passed while cut upstream");
   a_req_needs_en:
      assert property (($fell(chan_request_n) || $fell(single_cycle_request_n))
         |-> $past(chan_priority_enable))
      else $error("request posted without enable");
   a_req_cuts_out:
      assert property (req_any |-> !chan_priority_enable_out)
      else $error("enable passed on while requesting");
   a_grant_follows:
      assert property (req_any && !chan_grant |-> ##[1:2] chan_grant)
      else $error("request not granted");
   a_grant_length:
      assert property ($rose(chan_grant) |-> chan_grant[*5] ##1 !chan_grant)
      else $error("grant length wrong");
   a_no_req_grant:
      assert property ($rose(chan_grant) |-> $past(req_any))
      else $error("grant without request");
   a_addr_driven:
      assert property (chan_grant |-> !io_addr_oe_n)
      else $error("address not driven on grant");
   a_addr_released:
      assert property (!chan_grant |-> io_addr_n == '1)
      else $error("address bus not released");
   a_addr_stable:
      assert property (chan_grant && $past(chan_grant) |-> $stable(io_addr_n))
      else $error("address moved during grant");

   c_multi: cover property ($rose(chan_grant) && !chan_request_n);
   c_out: cover property ($rose(chan_grant) && chan_request_n);
   c_in: cover property ($rose(chan_grant) && !single_cycle_request_n
      && !chan_request_n);
endmodule : dcrc_assertions
`default_nettype wire

// >>> sim/test_data_channel_request_chain.sv
// Self-checking bench for the data channel request chain
`timescale 1ns/10ps
`default_nettype none
module test_data_channel_request_chain;
   localparam logic [5:0] CODE = 6'h2A;
   localparam logic [14:0] WC = 15'h2AC5;
   localparam logic [14:0] MA = 15'h5173;
   logic i_clk, i_reset_n, x_start, chain_en, iot_stb;
   logic dv_busy, dv_req, dv_done, dv_sel, pv_valid, dv_gnt, pv_busy;
   logic [5:0] iot_code;
   logic [14:0] pv_addr;
   dcrc_pkg::dcrc_xfer_t x_type, pv_type;
   int n_fail, cmp_count;

   dcrc_bus_if bus ();
   dcrc_device_end #(.DEV_CODE(CODE)) u_dcrc_device_end (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
      .i_xfer_start(x_start), .i_xfer_type(x_type),
      .i_wc_addr(WC), .i_mem_addr(MA), .o_busy(dv_busy),
      .o_requesting(dv_req), .o_granted(dv_gnt), .o_done(dv_done),
      .o_selected(dv_sel));
   dcrc_proc_end u_dcrc_proc_end (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
      .i_chain_enable(chain_en), .i_iot_strobe(iot_stb),
      .i_iot_dev_code(iot_code), .o_xfer_valid(pv_valid),
      .o_xfer_type(pv_type), .o_xfer_addr(pv_addr), .o_busy(pv_busy));
   dcrc_assertions u_dcrc_assertions (
      .i_clk(i_clk), .i_reset_n(i_reset_n),
      .chan_priority_enable(bus.chan_priority_enable),
      .chan_priority_enable_out(bus.chan_priority_enable_out),
      .chan_request_n(bus.chan_request_n),
      .single_cycle_request_n(bus.single_cycle_request_n),
      .chan_grant(bus.chan_grant), .io_addr_oe_n(bus.io_addr_oe_n),
      .io_addr_n(bus.io_addr_n));

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // Drive and sample 1 ns after the edge so no race with the design
   task tick();
      @(posedge i_clk);
      #1;
   endtask : tick

   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   task start(input dcrc_pkg::dcrc_xfer_t t);
      x_type = t;
      x_start = 1'b1;
      tick();
      x_start = 1'b0;
   endtask : start

   task finish(input dcrc_pkg::dcrc_xfer_t t);
      int n;
      logic [14:0] exp_a;
      n = 0;
      exp_a = (t == dcrc_pkg::XFER_MULTI) ? WC : MA;
      while (pv_valid !== 1'b1 && n < 40) begin
         tick();
         n++;
      end
      chk(pv_type === t, "wrong type");
      chk(pv_addr === exp_a, "addr");
      chk(bus.chan_priority_enable_out === 1'b0, "out high");
      chk(dv_gnt === 1'b1 && pv_busy === 1'b1, "no grant");
      while (dv_done !== 1'b1 && n < 80) begin
         tick();
         n++;
      end
      chk(dv_done === 1'b1, "no done");
      chk(dv_busy === 1'b0 && pv_busy === 1'b0, "still busy");
      tick();
      chk(bus.chan_priority_enable_out === 1'b1, "not passed");
   endtask : finish

   task t_types();
      dcrc_pkg::dcrc_xfer_t tl [3];
      tl = '{dcrc_pkg::XFER_MULTI, dcrc_pkg::XFER_IN, dcrc_pkg::XFER_OUT};
      foreach (tl[i]) begin
         start(tl[i]);
         finish(tl[i]);
      end
      $display("t_types end");
   endtask : t_types

   task t_none();
      start(dcrc_pkg::XFER_NONE);
      repeat (8) begin
         tick();
         chk(dv_busy === 1'b0 && bus.chan_grant === 1'b0, "started");
      end
      $display("t_none end");
   endtask : t_none

   task t_sel();
      iot_code = CODE;
      iot_stb = 1'b1;
      repeat (3) tick();
      chk(dv_sel === 1'b1, "own code missed");
      for (int i = 0; i < 6; i++) begin
         iot_code = CODE ^ (6'h01 << i);
         repeat (3) tick();
         chk(dv_sel === 1'b0, "foreign code taken");
      end
      iot_code = CODE;
      iot_stb = 1'b0;
      repeat (3) tick();
      chk(dv_sel === 1'b0, "taken without strobe");
      $display("t_sel end");
   endtask : t_sel

   task t_chain();
      chain_en = 1'b0;
      repeat (2) tick();
      chk(bus.chan_priority_enable === 1'b0, "head stuck");
      start(dcrc_pkg::XFER_MULTI);
      repeat (6) tick();
      chk(bus.chan_request_n === 1'b1 && dv_req === 1'b0, "posted");
      chk(bus.chan_priority_enable_out === 1'b0, "leak");
      chain_en = 1'b1;
      repeat (2) tick();
      chk(dv_req === 1'b1 && bus.chan_request_n === 1'b0, "no post");
      finish(dcrc_pkg::XFER_MULTI);
      $display("t_chain end");
   endtask : t_chain

   task wrap_up();
      $display("checks %0d fails %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      n_fail = 0;
      cmp_count = 0;
      i_reset_n = 1'b0;
      x_start = 1'b0;
      x_type = dcrc_pkg::XFER_NONE;
      chain_en = 1'b1;
      iot_stb = 1'b0;
      iot_code = 6'h00;
      repeat (8) @(posedge i_clk);
      #1 i_reset_n = 1'b1;
      tick();
      chk(bus.chan_priority_enable === 1'b1, "head low");
      t_types();
      t_none();
      t_sel();
      t_chain();
      wrap_up();
   end

   // Whole run is about a hundred cycles; this bound is generous
   initial begin
      #100000;
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
   end
endmodule : test_data_channel_request_chain
`default_nettype wire
